// ### logic/hie_host_irq_enable_set_clear.sv
// Purpose: host interrupt enable set/clear ports, readback and host pin
// Assumes: ports strobed by an outside address decoder, status given
// Notes:   pin is open drain, pulled low only while an enabled source is up
//          reserved status inputs never reach the pin or a read
//          write and read races are resolved in favour of the set port
`timescale 1ns/1ps
`default_nettype none

module hie_host_irq_enable_set_clear
  import hie_pkg::*;
#(
  parameter logic [31:0] MASK = DEFINED_MSK
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // set port access
  input  wire logic        setWrStrobe,
  input  wire logic        setRdStrobe,
  // clear port access
  input  wire logic        clrWrStrobe,
  input  wire logic        clrRdStrobe,
  // write data, read answer
  input  wire logic [31:0] wrData,
  output var  logic [31:0] rdData,
  output var  logic        rdValid,
  // internal status and power state
  input  wire logic [31:0] statusBits,
  input  wire logic [1:0]  powerState,
  // enable register view
  output var  logic [31:0] irqEnable,
  // host interrupt pin, open drain
  input  wire logic        hostIrqPinIn,
  output var  logic        hostIrqPinOut,
  output var  logic        hostIrqPinOeN,
  output var  logic        hostIrqLineLow
);

  // ************************************************************
  // enable store
  // ************************************************************
  hie_wr_if wrBus ();

  // both write ports share the data word; the store applies set after clear
  always_comb begin
    wrBus.setStrobe = setWrStrobe;
    wrBus.clrStrobe = clrWrStrobe;
    wrBus.data      = wrData;
  end

  hie_enable_store #(
    .MASK (MASK)
  ) u_store (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr      (wrBus.store)
  );

  // enable view is the store flop itself, no extra logic in between
  assign irqEnable = wrBus.enable;

  // ************************************************************
  // masked status and interrupt decision
  // ************************************************************
  logic [31:0] maskedStatus;
  logic        inD0;
  logic        irqActive;

  // reserved status inputs never reach the pin or a read
  always_comb begin
    maskedStatus = statusBits & wrBus.enable & MASK;
    inD0         = (powerState == PWR_D0);
    irqActive    = (|maskedStatus) && inD0;
  end

  // ************************************************************
  // register reads
  // ************************************************************
  logic [31:0] rdData_reg;
  logic [31:0] rdData_next;
  logic        rdValid_reg;

  // set port has priority if both reads land in one cycle
  always_comb begin
    if (setRdStrobe) begin
      rdData_next = wrBus.enable & MASK;
    end else if (clrRdStrobe) begin
      rdData_next = maskedStatus;
    end else begin
      rdData_next = rdData_reg;
    end
  end

  // answer is held until the next read replaces it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_reg <= READ_RST;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  // one-cycle valid marks a fresh answer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdValid_reg <= 1'b0;
    end else begin
      rdValid_reg <= setRdStrobe | clrRdStrobe;
    end
  end

  // read outputs straight from their flops
  assign rdData  = rdData_reg;
  assign rdValid = rdValid_reg;

  // ************************************************************
  // host interrupt pin
  // ************************************************************
  logic pinOeN_reg;
  logic pinOut_reg;
  logic lineLow_reg;

  // level interrupt: released one edge after the source, enable or D0 drops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOeN_reg <= OE_OFF_N;
    end else begin
      pinOeN_reg <= irqActive ? OE_ON_N : OE_OFF_N;
    end
  end

  // open drain only ever pulls low; the high level comes from the pull-up
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut_reg <= PIN_DRIVE_LVL;
    end else begin
      pinOut_reg <= PIN_DRIVE_LVL;
    end
  end

  // shared wire: other agents may hold it low too, so report the wire
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lineLow_reg <= 1'b0;
    end else begin
      lineLow_reg <= ~hostIrqPinIn;
    end
  end

  // pin outputs straight from their flops
  assign hostIrqPinOut  = pinOut_reg;
  assign hostIrqPinOeN  = pinOeN_reg;
  assign hostIrqLineLow = lineLow_reg;

  // ************************************************************
  // checks
  // ************************************************************
  // one edge after a write strobe the flop shows each written one
  AST_SOFT_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    setWrStrobe |=> ((irqEnable[SOFT_MSB:SOFT_LSB] & $past(wrData[SOFT_MSB:SOFT_LSB]))
                     == $past(wrData[SOFT_MSB:SOFT_LSB])))
    else $error("software enable not set by set port");

  AST_SOFT_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clrWrStrobe && !setWrStrobe)
      |=> ((irqEnable[SOFT_MSB:SOFT_LSB] & $past(wrData[SOFT_MSB:SOFT_LSB])) == 4'h0))
    else $error("software enable not cleared by clear port");

  AST_PERR_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (setWrStrobe && wrData[PERR_BIT]) |=> irqEnable[PERR_BIT])
    else $error("parity error enable not set");

  AST_PERR_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clrWrStrobe && !setWrStrobe && wrData[PERR_BIT])
      |=> !irqEnable[PERR_BIT] ##1 (!irqEnable[PERR_BIT] || ($past(setWrStrobe) && $past(wrData[PERR_BIT]))))
    else $error("parity error enable not cleared");

  AST_SERR_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (setWrStrobe && wrData[SERR_BIT]) |=> irqEnable[SERR_BIT])
    else $error("system error enable not set");

  AST_SERR_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clrWrStrobe && !setWrStrobe && wrData[SERR_BIT]) |=> !irqEnable[SERR_BIT])
    else $error("system error enable not cleared");

  AST_MABT_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (setWrStrobe && wrData[MABT_BIT]) |=> irqEnable[MABT_BIT])
    else $error("master abort enable not set");

  AST_MABT_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clrWrStrobe && !setWrStrobe && wrData[MABT_BIT]) |=> !irqEnable[MABT_BIT])
    else $error("master abort enable not cleared");

  AST_TABT_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (setWrStrobe && wrData[TABT_BIT]) |=> irqEnable[TABT_BIT])
    else $error("target abort enable not set");

  AST_TABT_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clrWrStrobe && !setWrStrobe && wrData[TABT_BIT]) |=> !irqEnable[TABT_BIT])
    else $error("target abort enable not cleared");

  // only a written one may move an enable bit
  AST_ZERO_KEEPS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> (((irqEnable ^ $past(irqEnable))
               & ~($past(wrData) & {32{$past(setWrStrobe) | $past(clrWrStrobe)}})) == 32'h0000_0000))
    else $error("enable bit changed without a written one");

  // pin decision lags status, enables and power by one edge
  AST_PIN_ASSERT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((|(statusBits & irqEnable & MASK)) && powerState == PWR_D0)
      |=> (hostIrqPinOeN == OE_ON_N) && (hostIrqPinOut == PIN_DRIVE_LVL))
    else $error("host pin not pulled low for enabled source in D0");

  AST_PIN_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(|(statusBits & irqEnable & MASK)) |=> (hostIrqPinOeN == OE_OFF_N))
    else $error("host pin held low with no enabled source");

  AST_PIN_LOWPOWER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (powerState != PWR_D0) |=> (hostIrqPinOeN == OE_OFF_N))
    else $error("host pin asserted outside D0");

  // read answers one edge after the strobe
  AST_READ_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    setRdStrobe |=> rdValid && (rdData == $past(irqEnable)))
    else $error("set port read did not return enables");

  AST_READ_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clrRdStrobe && !setRdStrobe)
      |=> rdValid && (rdData == ($past(statusBits) & $past(irqEnable) & MASK)))
    else $error("clear port read did not return masked status");

  AST_READ_RSVD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rdValid |-> ((rdData & ~MASK) == 32'h0000_0000))
    else $error("reserved read bits not zero");

  AST_VALID_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(setRdStrobe || clrRdStrobe) |=> !rdValid && $stable(rdData))
    else $error("read answer changed without a read");

  // nothing written, nothing moves; reads have no side effect on enables
  AST_ENABLE_HOLDS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(setWrStrobe || clrWrStrobe) |=> $stable(irqEnable))
    else $error("enable register moved without a write");

  // reserved enables stay clear as seen from outside as well
  AST_RSVD_ENABLE_OUT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (irqEnable & ~MASK) == 32'h0000_0000)
    else $error("reserved enable bit visible");

  // a one written to both ports in one cycle leaves the enable set
  AST_SET_WINS_OUT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (setWrStrobe && clrWrStrobe) |=> ((irqEnable & $past(wrData) & MASK) == ($past(wrData) & MASK)))
    else $error("set lost to a racing clear");

  // open drain: the drive value is never high, only the enable moves
  AST_PIN_DRIVE_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    hostIrqPinOut == PIN_DRIVE_LVL)
    else $error("host pin drive value not low");

  // a pulled pin must trace back to an enabled source one edge earlier
  AST_PIN_HAS_SOURCE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (hostIrqPinOeN == OE_ON_N) |-> (|($past(statusBits) & $past(irqEnable) & MASK)))
    else $error("host pin pulled low with no enabled source");

  // and to full power one edge earlier
  AST_PIN_ONLY_D0: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (hostIrqPinOeN == OE_ON_N) |-> ($past(powerState) == PWR_D0))
    else $error("host pin pulled low after a low power state");

  // wire report lags the wire by one edge
  AST_LINE_REPORT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> (hostIrqLineLow == !$past(hostIrqPinIn)))
    else $error("wire report does not follow the wire");

  // a fresh answer always has a read behind it
  AST_VALID_CAUSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rdValid |-> ($past(setRdStrobe) || $past(clrRdStrobe)))
    else $error("read answer without a read");

  // both ports read in one cycle: the set port answers
  AST_READ_BOTH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (setRdStrobe && clrRdStrobe) |=> rdValid && (rdData == $past(irqEnable)))
    else $error("simultaneous reads did not return enables");

  // main scenarios
  COV_SET_THEN_READ: cover property (@(posedge sys_clk) disable iff (!rst_n)
    setWrStrobe ##[1:3] setRdStrobe ##1 rdValid);

  COV_CLR_WRITE: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (clrWrStrobe && (|(wrData & irqEnable & MASK))));

  COV_PIN_LOW: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (hostIrqPinOeN == OE_OFF_N) ##1 (hostIrqPinOeN == OE_ON_N));

  COV_SUPPRESSED: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (|(statusBits & irqEnable & MASK)) && (powerState == PWR_D3));

  COV_SET_CLR_RACE: cover property (@(posedge sys_clk) disable iff (!rst_n)
    setWrStrobe && clrWrStrobe && (|(wrData & MASK)));

endmodule

`default_nettype wire

// ### logic/hie_pkg.sv
// Purpose: shared constants and types for the host interrupt enable block
// Assumes: 32-bit register data, one register clock sys_clk at 25 MHz
// Notes:   enable layout mirrors the internal status register bit for bit
//
// Function
// - set-port bits 27-24 set software enables
// - clear-port bits 27-24 clear software enables
// - set-port bit 6 sets parity error enable
// - clear-port bit 6 clears parity error enable
// - set-port bit 5 sets system error enable
// - clear-port bit 5 clears system error enable
// - set-port bit 2 sets master abort enable
// - clear-port bit 2 clears master abort enable
// - set-port bit 1 sets target abort enable
// - clear-port bit 1 clears target abort enable
// - written zeros leave enable bits unchanged
// - pin low when status AND enable in D0
// - pin never asserted in D1, D2, D3
// - set reads enables, clear reads masked status
`default_nettype none

package hie_pkg;

  // ************************************************************
  // register layout
  // ************************************************************
  localparam int          DATA_W      = 32;
  localparam int          SOFT_LSB    = 24;
  localparam int          SOFT_MSB    = 27;
  localparam int          PERR_BIT    = 6;
  localparam int          SERR_BIT    = 5;
  localparam int          MABT_BIT    = 2;
  localparam int          TABT_BIT    = 1;
  localparam logic [31:0] DEFINED_MSK = 32'h0F00_0066;
  localparam logic [31:0] ENABLE_RST  = 32'h0000_0000;
  localparam logic [31:0] READ_RST    = 32'h0000_0000;

  // ************************************************************
  // pin levels and power states
  // ************************************************************
  localparam logic PIN_DRIVE_LVL = 1'b0;
  localparam logic OE_ON_N       = 1'b0;
  localparam logic OE_OFF_N      = 1'b1;

  typedef enum logic [1:0] {
    PWR_D0 = 2'b00,
    PWR_D1 = 2'b01,
    PWR_D2 = 2'b10,
    PWR_D3 = 2'b11
  } hie_pwr_t;

endpackage

`default_nettype wire

// ### logic/hie_wr_if.sv
// Purpose: carries set/clear write requests to the enable store
// Assumes: one write data word shared by both ports
// Notes:   enable is the stored register, fed back to the controller
`timescale 1ns/1ps
`default_nettype none

interface hie_wr_if;
  // write request and stored value
  logic        setStrobe;
  logic        clrStrobe;
  logic [31:0] data;
  logic [31:0] enable;

  // ************************************************************
  // views
  // ************************************************************
  modport ctrl  (output setStrobe, output clrStrobe, output data, input enable);
  modport store (input setStrobe, input clrStrobe, input data, output enable);
endinterface

`default_nettype wire

// ### logic/hie_enable_store.sv
// Purpose: write-one-to-set / write-one-to-clear enable register
// Assumes: strobes are single-cycle and synchronous to sys_clk
// Notes:   a set and a clear in one cycle on one bit leave it set
`timescale 1ns/1ps
`default_nettype none

module hie_enable_store
  import hie_pkg::*;
#(
  parameter logic [31:0] MASK = DEFINED_MSK
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // request side
  hie_wr_if.store   wr
);

  // ************************************************************
  // next value
  // ************************************************************
  logic [31:0] enable_reg;
  logic [31:0] enable_next;
  logic [31:0] setBits;
  logic [31:0] clrBits;

  // reserved positions are masked off before they touch storage
  always_comb begin
    setBits     = wr.setStrobe ? (wr.data & MASK) : 32'h0000_0000;
    clrBits     = wr.clrStrobe ? (wr.data & MASK) : 32'h0000_0000;
    // set applied after clear so a racing set is never lost
    enable_next = (enable_reg & ~clrBits) | setBits;
  end

  // storage, all enables cleared at reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= ENABLE_RST;
    end else begin
      enable_reg <= enable_next;
    end
  end

  assign wr.enable = enable_reg;

  // ************************************************************
  // checks
  // ************************************************************
  AST_RSVD_STAYS_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (enable_reg & ~MASK) == 32'h0000_0000)
    else $error("reserved enable bit became set");

  AST_SET_BEATS_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr.setStrobe && wr.clrStrobe) |=> ((enable_reg & $past(wr.data) & MASK) == ($past(wr.data) & MASK)))
    else $error("simultaneous set lost to clear");

endmodule

`default_nettype wire

// ### tb/hie_host_wire_model.sv
// Purpose: shared host interrupt wire as the host side sees it
// Assumes: wire has a pull-up; other agents may only pull it low
// Notes:   level resolved from every party's enable, fed back to the device
`timescale 1ns/1ps
`default_nettype none

module hie_host_wire_model (
  // device side of the wire
  input  wire logic pinOut,
  input  wire logic pinOeN,
  // another agent sharing the wire
  input  wire logic otherPullLow,
  // resolved level
  output var  logic wireLevel
);
  // ************************************************************
  // wire resolution
  // ************************************************************
  // pull-up holds the wire high unless someone drives it
  always_comb begin
    wireLevel = 1'b1;
    if (pinOeN == 1'b0) begin
      wireLevel = pinOut; // level interrupt seen by host
    end
    if (otherPullLow) begin
      wireLevel = 1'b0; // open drain: any agent can pull low
    end
  end
endmodule

`default_nettype wire

// ### tb/hie_host_irq_enable_set_clear_tb.sv
// Purpose: self-checking bench for the host interrupt enable block
// Assumes: strobes are one-cycle pulses, inputs change at rising edges
// Notes:   exactness of latencies is left to the design's own assertions
`timescale 1ns/1ps
`default_nettype none

module hie_host_irq_enable_set_clear_tb;
  import hie_pkg::*;

  // ************************************************************
  // signals
  // ************************************************************
  logic        sys_clk, rst_n, setWrStrobe, setRdStrobe, clrWrStrobe, clrRdStrobe;
  logic [31:0] wrData, rdData, statusBits, irqEnable;
  logic [1:0]  powerState;
  logic        rdValid, hostIrqPinIn, hostIrqPinOut, hostIrqPinOeN, hostIrqLineLow, otherPullLow;
  int          fails, comparisons;
  int          bitPos[8] = '{24, 25, 26, 27, 6, 5, 2, 1};

  hie_host_irq_enable_set_clear dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .setWrStrobe(setWrStrobe),
    .setRdStrobe(setRdStrobe), .clrWrStrobe(clrWrStrobe), .clrRdStrobe(clrRdStrobe), .wrData(wrData),
    .rdData(rdData), .rdValid(rdValid), .statusBits(statusBits), .powerState(powerState),
    .irqEnable(irqEnable), .hostIrqPinIn(hostIrqPinIn), .hostIrqPinOut(hostIrqPinOut),
    .hostIrqPinOeN(hostIrqPinOeN), .hostIrqLineLow(hostIrqLineLow));

  hie_host_wire_model wire_u (.pinOut(hostIrqPinOut), .pinOeN(hostIrqPinOeN),
    .otherPullLow(otherPullLow), .wireLevel(hostIrqPinIn));

  // 25 MHz register clock
  always #20 sys_clk = ~sys_clk;

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic complete_run();
    if (fails == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // one-cycle write on either or both ports
  task automatic wr(input logic set, input logic clr, input logic [31:0] data);
    @(posedge sys_clk);
    setWrStrobe <= set;
    clrWrStrobe <= clr;
    wrData      <= data;
    @(posedge sys_clk);
    setWrStrobe <= 1'b0;
    clrWrStrobe <= 1'b0;
    @(negedge sys_clk);
  endtask

  // read one port, bounded wait for the answer
  task automatic rd(input logic fromSet, input logic [31:0] exp);
    int i;
    @(posedge sys_clk);
    setRdStrobe <= fromSet;
    clrRdStrobe <= ~fromSet;
    @(posedge sys_clk);
    setRdStrobe <= 1'b0;
    clrRdStrobe <= 1'b0;
    @(negedge sys_clk);
    for (i = 0; i < 4 && rdValid !== 1'b1; i++) begin
      @(negedge sys_clk);
    end
    check("rdValid", 32'h1, {31'h0, rdValid});
    if (rdValid !== 1'b1) begin
      complete_run();
    end
    check("rdData", exp, rdData);
  endtask

  // bounded wait for the pin enable, then the wire report
  task automatic pin(input logic expOeN, input logic expLow);
    int i;
    for (i = 0; i < 4 && hostIrqPinOeN !== expOeN; i++) begin
      @(negedge sys_clk);
    end
    check("hostIrqPinOeN", {31'h0, expOeN}, {31'h0, hostIrqPinOeN});
    if (hostIrqPinOeN !== expOeN) begin
      complete_run();
    end
    check("hostIrqPinOut", 32'h0, {31'h0, hostIrqPinOut});
    repeat (2) @(negedge sys_clk);
    check("hostIrqLineLow", {31'h0, expLow}, {31'h0, hostIrqLineLow});
  endtask

  // level inputs change at a rising edge like every other stimulus
  task automatic levels(input logic [31:0] status, input logic [1:0] power, input logic other);
    @(posedge sys_clk);
    statusBits   <= status;
    powerState   <= power;
    otherPullLow <= other;
    @(negedge sys_clk);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic test_reset();
    check("irqEnable", 32'h0000_0000, irqEnable);
    check("hostIrqPinOeN", 32'h1, {31'h0, hostIrqPinOeN});
    check("hostIrqPinOut", 32'h0, {31'h0, hostIrqPinOut});
    check("hostIrqLineLow", 32'h0, {31'h0, hostIrqLineLow});
    check("rdValid", 32'h0, {31'h0, rdValid});
    check("rdData", 32'h0000_0000, rdData);
    rd(1'b1, 32'h0000_0000);
  endtask

  // each defined bit set then cleared one at a time, others must stay
  task automatic test_each_bit();
    logic [31:0] acc;
    acc = 32'h0000_0000;
    foreach (bitPos[k]) begin
      acc[bitPos[k]] = 1'b1;
      wr(1'b1, 1'b0, 32'h1 << bitPos[k]);
      check("irqEnable", acc, irqEnable);
    end
    foreach (bitPos[k]) begin
      acc[bitPos[k]] = 1'b0;
      wr(1'b0, 1'b1, 32'h1 << bitPos[k]);
      check("irqEnable", acc, irqEnable);
    end
  endtask

  // reserved positions ignored, zeros ignored, readback masked
  task automatic test_reserved_and_zero();
    wr(1'b1, 1'b0, 32'hFFFF_FFFF);
    check("irqEnable", 32'h0F00_0066, irqEnable);
    rd(1'b1, 32'h0F00_0066);
    wr(1'b0, 1'b1, 32'hF0FF_FF99);
    check("irqEnable", 32'h0F00_0066, irqEnable);
    wr(1'b1, 1'b1, 32'h0000_0000);
    check("irqEnable", 32'h0F00_0066, irqEnable);
    wr(1'b0, 1'b1, 32'h0500_0022);
    check("irqEnable", 32'h0A00_0044, irqEnable);
  endtask

  // clear port reads status AND enable; low power keeps the pin released
  task automatic test_masked_read();
    levels(32'hFFFF_FFFF, PWR_D1, 1'b0);
    pin(1'b1, 1'b0);
    rd(1'b0, 32'h0A00_0044);
    levels(32'h0300_0006, PWR_D1, 1'b0);
    rd(1'b0, 32'h0200_0004);
    levels(32'h0000_0000, PWR_D1, 1'b0);
    wr(1'b0, 1'b1, 32'hFFFF_FFFF);
  endtask

  // set and clear racing on one word: set wins; both reads: set port answers
  task automatic test_races();
    wr(1'b1, 1'b1, 32'h0100_0002);
    check("irqEnable", 32'h0100_0002, irqEnable);
    @(posedge sys_clk);
    setRdStrobe <= 1'b1;
    clrRdStrobe <= 1'b1;
    @(posedge sys_clk);
    setRdStrobe <= 1'b0;
    clrRdStrobe <= 1'b0;
    @(negedge sys_clk);
    check("rdValid", 32'h1, {31'h0, rdValid});
    check("rdData", 32'h0100_0002, rdData);
    wr(1'b0, 1'b1, 32'h0100_0002);
    check("irqEnable", 32'h0000_0000, irqEnable);
  endtask

  // pin follows enabled status in D0 only
  task automatic test_pin();
    levels(32'h0000_0040, PWR_D0, 1'b0);
    wr(1'b1, 1'b0, 32'h0000_0020);
    pin(1'b1, 1'b0);
    wr(1'b1, 1'b0, 32'h0000_0040);
    pin(1'b0, 1'b1);
    levels(32'h0000_0040, PWR_D1, 1'b0);
    pin(1'b1, 1'b0);
    levels(32'h0000_0040, PWR_D0, 1'b0);
    pin(1'b0, 1'b1);
    levels(32'h0000_0040, PWR_D2, 1'b0);
    pin(1'b1, 1'b0);
    levels(32'h0000_0040, PWR_D3, 1'b0);
    pin(1'b1, 1'b0);
    levels(32'h0000_0040, PWR_D0, 1'b0);
    pin(1'b0, 1'b1);
    wr(1'b0, 1'b1, 32'h0000_0040);
    pin(1'b1, 1'b0);
    levels(32'h0000_0040, PWR_D0, 1'b1);
    pin(1'b1, 1'b1);
    levels(32'h0000_0040, PWR_D0, 1'b0);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    sys_clk      = 1'b0;
    rst_n        = 1'b0;
    setWrStrobe  = 1'b0;
    setRdStrobe  = 1'b0;
    clrWrStrobe  = 1'b0;
    clrRdStrobe  = 1'b0;
    wrData       = 32'h0000_0000;
    statusBits   = 32'h0000_0000;
    powerState   = PWR_D0;
    otherPullLow = 1'b0;
    fails        = 0;
    comparisons  = 0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    test_reset();
    test_each_bit();
    test_reserved_and_zero();
    test_masked_read();
    test_races();
    test_pin();
    complete_run();
  end
endmodule

`default_nettype wire
